// *** rtl/fbs_params.svh ***
// Purpose: constants for the FSK byte serial interface
// Assumes: 250 MHz core clock, 1200 baud line
// Notes: times in ns except the carrier hold in ms, counts derived from the clock period
`ifndef FBS_PARAMS_SVH
`define FBS_PARAMS_SVH
`define FBS_CLK_PERIOD_NS 4
`define FBS_BAUD 1200
`define FBS_BIT_TIME_NS (1000000000 / `FBS_BAUD)
`define FBS_BIT_CYCLES (`FBS_BIT_TIME_NS / `FBS_CLK_PERIOD_NS)
`define FBS_HALF_CYCLES (`FBS_BIT_CYCLES / 2)
`define FBS_CD_HOLD_MS 10
`define FBS_CD_HOLD_CYCLES (`FBS_CD_HOLD_MS * 1000000 / `FBS_CLK_PERIOD_NS)
`define FBS_DATA_BITS 8
`define FBS_BUF_BITS 9
`define FBS_CNT_W 32
`define FBS_BITIDX_W 4
`endif

// *** rtl/fbs_pkg.sv ***
// Purpose: shared types for the FSK byte serial interface
// Assumes: included constants header
// Notes: frame result carried as one packed struct
package fbs_pkg;
  typedef enum logic [2:0] {
    FBS_IDLE,
    FBS_START,
    FBS_DATA,
    FBS_STOP
  } fbs_rx_e;

  // One received frame, handed from the framer to the output logic
  typedef struct packed {
    logic [7:0] data;
    logic stop_bit;
  } fbs_frame_s;
endpackage

// *** rtl/fbs_sync.sv ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock, synchronous active-low reset
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module fbs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Next values
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Register stages, preset to the idle level
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule

// *** rtl/fbs_carrier_hold.sv ***
// Purpose: stretches carrier activity into a held carrier-present flag
// Assumes: activity input already synchronised
// Notes: release only after a full quiet interval
`timescale 1ns/100ps
`include "fbs_params.svh"
module fbs_carrier_hold
  import fbs_pkg::*;
#(
  parameter int HOLD_CYCLES = `FBS_CD_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic activity,
  output logic carrier_on
);
  logic [`FBS_CNT_W-1:0] quiet_q;
  logic [`FBS_CNT_W-1:0] quiet_d;
  logic on_q;
  logic on_d;

  // Any activity reloads the quiet timer; dropouts are bridged
  always_comb begin
    quiet_d = quiet_q;
    on_d = on_q;
    if (activity) begin
      quiet_d = '0;
      on_d = 1'b1; // R18
    end else if (on_q) begin
      if (quiet_q >= HOLD_CYCLES[`FBS_CNT_W-1:0] - 32'h1) begin
        on_d = 1'b0; // R18
        quiet_d = '0;
      end else begin
        quiet_d = quiet_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      quiet_q <= '0;
      on_q <= 1'b0;
    end else begin
      quiet_q <= quiet_d;
      on_q <= on_d;
    end
  end

  assign carrier_on = on_q;
endmodule

// *** rtl/fbs_serial_if.sv ***
// Purpose: framer and three-wire output of an FSK caller-id receiver
// Assumes: demodulated bits arrive as a level (1 = mark), async to clock
// Notes: shared output pin is byte ready in FSK mode, tone detect otherwise
// Notes on behaviour
// R1: mode pin low streams, high buffers
// R2: stream mode drives data, clock, ready outputs
// R3: eight clock pulses per received byte
// R4: clock rising edge at bit centre
// R5: no clock pulses for framing bits
// R6: ready low first half of stop bit
// R7: buffer mode loads nine bits mid stop
// R8: external clock edges shift buffered bits out
// R9: reader finishes shifting before next ready
// R10: reader holds clock low around ready fall
// R11: first reader edge releases ready early
// R12: ninth bit out is stop bit
// R13: shared pin shows ready when FSK selected
// R14: mark is one, space is zero
// R15: all timing fixed at 1200 baud
// R16: host decides message end
// R17: no carrier forces idle outputs; the code forces the data pin high in stream mode only
// R18: carrier held through dropouts for 10ms
// R19: resync on start edge, sample at centre
`timescale 1ns/100ps
`include "fbs_params.svh"
module fbs_serial_if
  import fbs_pkg::*;
#(
  parameter int BIT_CYCLES = `FBS_BIT_CYCLES,
  parameter int CD_HOLD_CYCLES = `FBS_CD_HOLD_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic demod_bit,
  input wire logic band_activity,
  input wire logic mode_select_pin,
  input wire logic fsk_selected,
  input wire logic tone_detect_n,
  input wire logic serial_bit_clock_in,
  output logic serial_bit_clock_out,
  output logic serial_bit_clock_oe,
  output logic serial_data,
  output logic shared_ready_tone_out,
  output logic carrier_present_n
);
  // Half-bit point derived from the nominal bit period, no rate tracking
  localparam int HALF = BIT_CYCLES / 2; // R15

  // Pin inputs through two flops each
  logic [4:0] pins_s;
  // Reader clock presets low like its idle level, so no false edge after reset
  fbs_sync #(.WIDTH(5), .INIT(5'h1e)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({demod_bit, mode_select_pin, fsk_selected, tone_detect_n, serial_bit_clock_in}),
    .sync_out(pins_s)
  );
  logic bit_s;
  logic mode_s;
  logic fsk_s;
  logic tone_s;
  logic ext_clk_s;
  assign bit_s = pins_s[4]; // R14
  assign mode_s = pins_s[3]; // R1
  assign fsk_s = pins_s[2];
  assign tone_s = pins_s[1];
  assign ext_clk_s = pins_s[0];

  logic act_s;
  fbs_sync #(.WIDTH(1), .INIT(1'h0)) u_sync_act (
    .clock(clock),
    .rst_n(rst_n),
    .async_in(band_activity),
    .sync_out(act_s)
  );

  logic carrier_on;
  fbs_carrier_hold #(.HOLD_CYCLES(CD_HOLD_CYCLES)) u_cd (
    .clock(clock),
    .rst_n(rst_n),
    .activity(act_s),
    .carrier_on(carrier_on)
  );

  // Framer state
  fbs_rx_e st_q;
  fbs_rx_e st_d;
  logic [`FBS_CNT_W-1:0] cnt_q;
  logic [`FBS_CNT_W-1:0] cnt_d;
  logic [`FBS_BITIDX_W-1:0] idx_q;
  logic [`FBS_BITIDX_W-1:0] idx_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic bit_prev_q;
  logic bit_prev_d;
  logic serial_bit_clock_q;
  logic serial_bit_clock_d;
  logic rdy_q;
  logic rdy_d;
  logic [`FBS_CNT_W-1:0] rdy_cnt_q;
  logic [`FBS_CNT_W-1:0] rdy_cnt_d;
  logic frame_done;
  fbs_frame_s frame;

  // Bit timing: resync on start edge, sample centres, emit stream clock
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 32'h1;
    idx_d = idx_q;
    sh_d = sh_q;
    bit_prev_d = bit_s;
    serial_bit_clock_d = serial_bit_clock_q;
    frame_done = 1'b0;
    frame.data = sh_q;
    frame.stop_bit = bit_s;
    if (!carrier_on) begin
      st_d = FBS_IDLE; // R17
      serial_bit_clock_d = 1'b1;
      cnt_d = '0;
    end else begin
      case (st_q)
        FBS_IDLE: begin
          cnt_d = '0;
          serial_bit_clock_d = 1'b1;
          if (bit_prev_q && !bit_s) begin
            st_d = FBS_START; // R19
          end
        end
        FBS_START: begin
          if (cnt_q == HALF[`FBS_CNT_W-1:0] - 32'h1) begin
            if (bit_s) begin
              st_d = FBS_IDLE; // false start, glitch rejected
            end else begin
              st_d = FBS_DATA;
              cnt_d = '0;
              idx_d = '0;
            end
          end
        end
        FBS_DATA: begin
          // Clock low in first half of each data cell, rises at centre
          if (cnt_q == BIT_CYCLES[`FBS_CNT_W-1:0] - 32'h1) begin
            cnt_d = '0;
            serial_bit_clock_d = 1'b1; // R4
            sh_d = {bit_s, sh_q[7:1]};
            if (idx_q == 4'(`FBS_DATA_BITS - 1)) begin
              st_d = FBS_STOP;
            end else begin
              idx_d = idx_q + 4'h1;
            end
          end else if (cnt_q == HALF[`FBS_CNT_W-1:0] - 32'h1) begin
            serial_bit_clock_d = 1'b0; // R3 R5
          end
        end
        FBS_STOP: begin
          serial_bit_clock_d = 1'b1; // R5
          if (cnt_q == BIT_CYCLES[`FBS_CNT_W-1:0] - 32'h1) begin
            frame_done = 1'b1; // R7
            st_d = FBS_IDLE;
            cnt_d = '0;
          end
        end
        default: begin
          st_d = FBS_IDLE;
        end
      endcase
    end
  end

  // Byte ready and nine-bit buffer
  logic [8:0] buf_q;
  logic [8:0] buf_d;
  logic ext_prev_q;
  logic ext_prev_d;
  logic ext_rise;
  logic stop_start;
  assign ext_rise = ext_clk_s && !ext_prev_q;
  // Stop cell begins half a bit after the eighth data centre has been sampled
  assign stop_start = (st_q == FBS_STOP) && (cnt_q == HALF[`FBS_CNT_W-1:0]);

  always_comb begin
    rdy_d = rdy_q;
    rdy_cnt_d = rdy_cnt_q;
    buf_d = buf_q;
    ext_prev_d = ext_clk_s;
    if (!carrier_on) begin
      rdy_d = 1'b1; // R17
      rdy_cnt_d = '0;
    end else if (!mode_s) begin
      // Stream mode: low from stop start for half a bit
      if (stop_start) begin
        rdy_d = 1'b0; // R6
        rdy_cnt_d = '0;
      end else if (!rdy_q) begin
        rdy_cnt_d = rdy_cnt_q + 32'h1;
        if (rdy_cnt_q == HALF[`FBS_CNT_W-1:0] - 32'h2) begin
          rdy_d = 1'b1; // R6
        end
      end
    end else begin
      if (frame_done) begin
        buf_d = {frame.stop_bit, frame.data}; // R7 R12
        rdy_d = 1'b0; // R7
        rdy_cnt_d = '0;
      end else begin
        if (ext_rise) begin
          buf_d = {1'b1, buf_q[8:1]}; // R8
        end
        if (!rdy_q) begin
          rdy_cnt_d = rdy_cnt_q + 32'h1;
          // Reader edge releases early; a reader that waits sees 1/2400 s
          if (ext_rise || rdy_cnt_q == HALF[`FBS_CNT_W-1:0] - 32'h1) begin
            rdy_d = 1'b1; // R11
          end
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_q <= FBS_IDLE;
      cnt_q <= '0;
      idx_q <= '0;
      sh_q <= '0;
      bit_prev_q <= 1'b1;
      serial_bit_clock_q <= 1'b1;
      rdy_q <= 1'b1;
      rdy_cnt_q <= '0;
      buf_q <= 9'h1ff;
      ext_prev_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      sh_q <= sh_d;
      bit_prev_q <= bit_prev_d;
      serial_bit_clock_q <= serial_bit_clock_d;
      rdy_q <= rdy_d;
      rdy_cnt_q <= rdy_cnt_d;
      buf_q <= buf_d;
      ext_prev_q <= ext_prev_d;
    end
  end

  // Output registers; data delayed so edges line up with clock
  logic data_q;
  logic data_d;
  logic clk_out_q;
  logic clk_out_d;
  logic pin_q;
  logic pin_d;
  always_comb begin
    if (!carrier_on && !mode_s) begin
      data_d = 1'b1; // R17
    end else if (mode_s) begin
      data_d = buf_q[0]; // R8
    end else begin
      data_d = bit_s; // R2
    end
    clk_out_d = carrier_on ? serial_bit_clock_q : 1'b1; // R2 R17
    pin_d = fsk_s ? rdy_q : tone_s; // R13
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      data_q <= 1'b1;
      clk_out_q <= 1'b1;
      pin_q <= 1'b1;
    end else begin
      data_q <= data_d;
      clk_out_q <= clk_out_d;
      pin_q <= pin_d;
    end
  end

  // Clock pin driven only in stream mode, input in buffer mode
  assign serial_bit_clock_oe = ~mode_s; // R1 R8
  assign serial_bit_clock_out = clk_out_q;
  assign serial_data = data_q;
  assign shared_ready_tone_out = pin_q;
  assign carrier_present_n = ~carrier_on;
endmodule

// *** tb/fbs_serial_if_sva.sv ***
// Purpose: port checks for the FSK byte serial interface
// Assumes: one clock, sync active-low reset
// Notes: bit counts follow the bound parameters
`timescale 1ns/100ps
module fbs_serial_if_sva #(
  parameter int BIT_CYCLES = 100,
  parameter int CD_HOLD_CYCLES = 2000
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic band_activity,
  input wire logic mode_select_pin,
  input wire logic fsk_selected,
  input wire logic tone_detect_n,
  input wire logic serial_bit_clock_in,
  input wire logic serial_bit_clock_out,
  input wire logic serial_bit_clock_oe,
  input wire logic serial_data,
  input wire logic shared_ready_tone_out,
  input wire logic carrier_present_n
);
  localparam int HALF = BIT_CYCLES / 2;
  int low_q;
  int quiet_q;
  logic [3:0] rise_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Ready low span, quiet span, clock rises since the last ready fall
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      low_q <= 0;
      quiet_q <= 0;
      rise_q <= 4'h0;
    end else begin
      low_q <= shared_ready_tone_out ? 0 : low_q + 1;
      quiet_q <= band_activity ? 0 : (quiet_q > CD_HOLD_CYCLES + 20 ? quiet_q : quiet_q + 1);
      if (!serial_bit_clock_oe || $fell(shared_ready_tone_out)) rise_q <= 4'h0;
      else if ($rose(serial_bit_clock_out)) rise_q <= rise_q + 4'h1;
    end
  end
  sequence s_byte_end;
    $fell(shared_ready_tone_out) && serial_bit_clock_oe && fsk_selected;
  endsequence
  sequence s_first_read;
    !shared_ready_tone_out && !serial_bit_clock_oe && fsk_selected && $rose(serial_bit_clock_in);
  endsequence
  a_mode_drive: assert property ($changed(mode_select_pin) |-> ##[1:4] serial_bit_clock_oe == !mode_select_pin)
    else $error("clock drive does not follow mode");
  a_burst_eight: assert property (s_byte_end |-> rise_q == 4'h8)
    else $error("burst is not eight pulses");
  a_rise_center: assert property ($rose(serial_bit_clock_out) && serial_bit_clock_oe |-> $stable(serial_data)[*8])
    else $error("data moves near clock rise");
  a_ready_half: assert property ($rose(shared_ready_tone_out) && serial_bit_clock_oe && fsk_selected
    |-> low_q inside {[HALF - 2:HALF + 1]})
    else $error("stream ready width wrong");
  a_buf_release: assert property (s_first_read |-> ##[1:5] shared_ready_tone_out)
    else $error("ready not released by reader");
  a_buf_max: assert property (fsk_selected && !serial_bit_clock_oe && !shared_ready_tone_out |-> low_q <= HALF + 2)
    else $error("buffer ready too long");
  a_stream_idle: assert property ((carrier_present_n && serial_bit_clock_oe)[*3] |-> serial_data && serial_bit_clock_out)
    else $error("stream pins not idle");
  a_ready_quiet: assert property ((carrier_present_n && fsk_selected)[*3] |-> shared_ready_tone_out)
    else $error("ready low without carrier");
  a_tone_pass: assert property ((!fsk_selected && $stable(tone_detect_n))[*5] |-> shared_ready_tone_out == tone_detect_n)
    else $error("tone level not shown");
  a_carrier_hold: assert property (!carrier_present_n && quiet_q < CD_HOLD_CYCLES |=> !carrier_present_n)
    else $error("carrier dropped early");
  a_carrier_drop: assert property (quiet_q == CD_HOLD_CYCLES + 12 |-> carrier_present_n)
    else $error("carrier kept too long");
endmodule
bind fbs_serial_if fbs_serial_if_sva #(.BIT_CYCLES(BIT_CYCLES), .CD_HOLD_CYCLES(CD_HOLD_CYCLES)) u_sva (.*);

// *** tb/fbs_reader_model.sv ***
// Purpose: reader on the three-wire side
// Assumes: clock pin level given as a resolved wire
// Notes: captures on every wire rise in both modes
`timescale 1ns/100ps
module fbs_reader_model #(
  parameter int HOLD = 4
) (
  input wire logic clock,
  input wire logic enable,
  input wire logic ready_n,
  input wire logic data,
  input wire logic serial_bit_clock_wire,
  output logic rd_clk,
  output logic [8:0] word_q
);
  int frame_errs = 0;
  initial rd_clk = 1'b0;
  // Shift in at each rise, oldest bit ends lowest
  always @(posedge serial_bit_clock_wire) word_q <= {data, word_q[8:1]};
  // Clock held low past ready fall, nine reads, done long before next byte
  always @(negedge ready_n) if (enable) begin
    repeat (HOLD) @(posedge clock);
    repeat (9) begin
      #1 rd_clk = 1'b1;
      repeat (6) @(posedge clock);
      #1 rd_clk = 1'b0;
      repeat (6) @(posedge clock);
    end
    // Host side framing check counts stop bits read as zero
    if (!word_q[8]) frame_errs++;
  end
endmodule

// *** tb/fbs_serial_if_test.sv ***
// Purpose: self-checking bench for the FSK byte serial interface
// Assumes: short bit and hold counts
// Notes: inputs change on falling clock edges
`timescale 1ns/100ps
module fbs_serial_if_test;
  localparam int BITC = 100;
  localparam int HOLDC = 2000;
  localparam int HALF = BITC / 2;
  logic clock, rst_n, demod_bit, band_activity, mode_select_pin, fsk_selected, tone_detect_n;
  logic serial_bit_clock_in, serial_bit_clock_out, serial_bit_clock_oe;
  logic serial_data, shared_ready_tone_out, carrier_present_n, rd_clk, rd_en;
  logic [8:0] word_q;
  int num_errors = 0;
  int total_checks = 0;
  // Shared clock pin: design drives it in stream mode, reader otherwise
  assign serial_bit_clock_in = serial_bit_clock_oe ? serial_bit_clock_out : rd_clk;
  fbs_serial_if #(.BIT_CYCLES(BITC), .CD_HOLD_CYCLES(HOLDC)) uut (.*);
  fbs_reader_model rdr (.clock(clock), .enable(rd_en), .ready_n(shared_ready_tone_out), .data(serial_data),
    .serial_bit_clock_wire(serial_bit_clock_in), .rd_clk(rd_clk), .word_q(word_q));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Start low, data LSB first, then stop level
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clock) demod_bit = f[i];
      repeat (BITC - 1) @(negedge clock);
    end
    @(negedge clock) demod_bit = 1'b1;
  endtask
  // Back-to-back bytes captured by the reader
  task automatic t_stream();
    logic [7:0] v [2] = '{8'ha5, 8'h5a};
    for (int i = 0; i < 2; i++) begin
      send(v[i], 1'b1);
      check("stream byte", {1'b0, word_q[8:1]}, {1'b0, v[i]});
    end
  endtask
  // Good frame then a framing error, both read out
  task automatic t_buffer();
    logic [8:0] w [2] = '{9'h1c3, 9'h081};
    @(negedge clock) mode_select_pin = 1'b1;
    rd_en = 1'b1;
    repeat (10) @(negedge clock);
    for (int i = 0; i < 2; i++) begin
      send(w[i][7:0], w[i][8]);
      repeat (2 * BITC) @(negedge clock);
      check("buffer word", word_q, w[i]);
    end
    check("framing errors", 9'(rdr.frame_errs), 9'h1);
  endtask
  // Nobody reads: ready stands half a bit
  task automatic t_noread();
    int w = 0;
    int n = 0;
    rd_en = 1'b0;
    fork
      send(8'h7e, 1'b1);
      begin
        while (shared_ready_tone_out !== 1'b0 && w < 3000) begin
          @(negedge clock);
          w++;
        end
        while (shared_ready_tone_out === 1'b0 && n < 3000) begin
          @(negedge clock);
          n++;
        end
      end
    join
    check("ready span", 9'(n >= HALF - 2 && n <= HALF + 2), 9'h1);
  endtask
  // Carrier loss: held through the gap, then stream pins forced high
  task automatic t_nocarrier();
    @(negedge clock) band_activity = 1'b0;
    mode_select_pin = 1'b0;
    repeat (HOLDC - 20) @(negedge clock);
    check("carrier held", 9'(carrier_present_n), 9'h0);
    repeat (60) @(negedge clock);
    check("carrier gone", 9'(carrier_present_n), 9'h1);
    demod_bit = 1'b0;
    repeat (BITC) @(negedge clock);
    check("idle pins", 9'({serial_data, serial_bit_clock_out, shared_ready_tone_out}), 9'h7);
    demod_bit = 1'b1;
    band_activity = 1'b1;
  endtask
  task automatic t_tone();
    @(negedge clock) fsk_selected = 1'b0;
    tone_detect_n = 1'b0;
    repeat (6) @(negedge clock);
    check("tone low", 9'(shared_ready_tone_out), 9'h0);
    tone_detect_n = 1'b1;
    repeat (6) @(negedge clock);
    check("tone high", 9'(shared_ready_tone_out), 9'h1);
    fsk_selected = 1'b1;
  endtask
  initial begin
    rst_n = 1'b0;
    demod_bit = 1'b1;
    band_activity = 1'b1;
    mode_select_pin = 1'b0;
    fsk_selected = 1'b1;
    tone_detect_n = 1'b1;
    rd_en = 1'b0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (20) @(negedge clock);
    t_stream();
    t_buffer();
    t_noread();
    t_nocarrier();
    t_tone();
    test_done();
  end
  // Run needs about 8000 cycles
  initial begin
    #(4 * 20000);
    num_errors++;
    test_done();
  end
endmodule
